/* File: pkg/switch_output_defs.vh */
// Constants for the switch output control block.
// Assumes a 50 MHz ref_clk and a 32-bit classic Wishbone register port.
`ifndef SWITCH_OUTPUT_DEFS_VH
`define SWITCH_OUTPUT_DEFS_VH

// Register byte offsets
`define SW_CTRL_OFS      8'h00
`define SW_ON_VAL_OFS    8'h04
`define SW_OFF_VAL_OFS   8'h08
`define SW_ON_DLY_OFS    8'h0C
`define SW_OFF_DLY_OFS   8'h10
`define SW_STATUS_OFS    8'h14

// Control register fields
`define CTRL_FUNC_LSB    0
`define CTRL_SRC_LSB     4
`define CTRL_DIAG_LSB    6
`define CTRL_FAIL_LSB    8
`define CTRL_INV_BIT     10
`define CTRL_VAR_LSB     12

// Function selection
`define FUNC_OFF         3'h0
`define FUNC_ON          3'h1
`define FUNC_DIAG        3'h2
`define FUNC_LIMIT       3'h3
`define FUNC_DIGITAL     3'h4

// Status source
`define SRC_NONE         2'h0
`define SRC_BLOCK1       2'h1
`define SRC_BLOCK2       2'h2

// Diagnostic class
`define DIAG_ALARM       2'h0
`define DIAG_ALARM_WARN  2'h1
`define DIAG_WARN        2'h2

// Failure selection
`define FAIL_ACTUAL      2'h0
`define FAIL_OPEN        2'h1
`define FAIL_CLOSED      2'h2

`define VAR_NONE         4'h0

// Reset values
`define CTRL_RESET       32'h0000_0100
`define DLY_RESET        32'h0000_0000

// Delay unit is 0.1 s; entries 0 to 1000 cover 0.0 to 100.0 s
`define DLY_MAX          32'h0000_03E8
`define CLK_HZ           50000000
`define TENTH_S_NS       100000000
`define CLK_NS           20
`define TENTH_CYCLES     (`TENTH_S_NS / `CLK_NS)

`endif

/* File: rtl/switch_output_control.v */
// Switch output control: forced, diagnostic, limit and tracking modes.
// Assumes synchronous inputs on ref_clk and a classic Wishbone master.
// Thresholds are signed words; delays count tenths of a second of ref_clk.
// Contract
// - In digital tracking the switch follows the binary output of the selected diagnostic block.
// - The status source picks none, block one or block two, resets to none, and acts only in tracking.
// - Limit mode compares one selected process variable, whose selection resets to none.
// - Diagnostic mode opens on alarm only, alarm or warning, or warning only, resetting to alarm only.
// - With on above off, close when the value rises above on and open when it falls below off.
// - With on below off, close when the value falls below on and open when it rises above off.
// - On alarm the switch keeps its state, opens or closes per the failure selection, reset open; forced off and on ignore the alarm here.
// - Software can read the present open or closed state of the switch.
// - Inversion, reset off, swaps open and closed for every other behaviour.
// - Forced off and on choices simulate the output independent of measurement.
// - Function off holds the switch open.
// - Function on holds the switch closed.
// - Diagnostic mode rests closed and opens only while a selected event is present.
// - Limit mode rests closed and opens only when the variable crosses the limit; here it rests open and closes when the variable crosses the on limit.
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "switch_output_defs.vh"

module switch_output_control #(
    parameter VAL_W       = 32,
    parameter TENTH_TICKS = `TENTH_CYCLES
) (
    // Clock, reset, enable
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             clk_en,
    // Wishbone slave
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    // Measurement and diagnostics
    input  wire [16*VAL_W-1:0] proc_vars,
    input  wire             diag_alarm,
    input  wire             diag_warning,
    input  wire             discrete_function_block1,
    input  wire             discrete_function_block2,
    // Load side
    output reg              switch_closed
);

    reg  [31:0]      ctrl_r;
    reg  [VAL_W-1:0] on_val_r;
    reg  [VAL_W-1:0] off_val_r;
    reg  [9:0]       on_dly_r;
    reg  [9:0]       off_dly_r;
    reg              limit_state_r;
    reg  [31:0]      tick_cnt_r;
    reg  [9:0]       dly_cnt_r;
    reg              pending_r;

    wire [2:0] func     = ctrl_r[`CTRL_FUNC_LSB +: 3];
    wire [1:0] src_sel  = ctrl_r[`CTRL_SRC_LSB +: 2];
    wire [1:0] diag_sel = ctrl_r[`CTRL_DIAG_LSB +: 2];
    wire [1:0] fail_sel = ctrl_r[`CTRL_FAIL_LSB +: 2];
    wire       invert   = ctrl_r[`CTRL_INV_BIT];
    wire [3:0] var_sel  = ctrl_r[`CTRL_VAR_LSB +: 4];

    // Unpack the process variable slots; slot zero stands for none
    wire [VAL_W-1:0] pv_slot [0:15];
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_slot
            assign pv_slot[g] = proc_vars[g*VAL_W +: VAL_W];
        end
    endgenerate

    wire signed [VAL_W-1:0] meas = pv_slot[var_sel];
    wire signed [VAL_W-1:0] on_s  = on_val_r;
    wire signed [VAL_W-1:0] off_s = off_val_r;

    // Wishbone access
    wire       wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr   = wb_req & wb_we_i & (&wb_sel_i);
    // Out-of-range delays clamp rather than wrap, so 1024 never reads as 0
    localparam [9:0] DLY_CLAMP = 10'h3E8;
    wire [9:0] dly_in  = (wb_dat_i[31:0] > `DLY_MAX) ? DLY_CLAMP : wb_dat_i[9:0];

    // Limit comparator: wants-closed and wants-open conditions
    reg close_cond;
    reg open_cond;
    always @* begin
        close_cond = 1'b0;
        open_cond  = 1'b0;
        if (var_sel != `VAR_NONE) begin
            if (on_s > off_s) begin
                close_cond = meas > on_s;
                open_cond  = meas < off_s;
            end else if (on_s < off_s) begin
                close_cond = meas < on_s;
                open_cond  = meas > off_s;
            end else begin
                // Equal thresholds: close above, open below
                close_cond = meas > on_s;
                open_cond  = meas < off_s;
            end
        end
    end

    // Target of a pending limit transition; neither means hold
    wire want_change = limit_state_r ? open_cond : close_cond;
    wire [9:0] dly_sel = limit_state_r ? off_dly_r : on_dly_r;
    wire tick = (tick_cnt_r == TENTH_TICKS - 1);

    // Computed state before failure override and inversion
    reg diag_event;
    reg track_bit;
    reg base_closed;
    always @* begin
        case (diag_sel)
            `DIAG_ALARM:      diag_event = diag_alarm;
            `DIAG_ALARM_WARN: diag_event = diag_alarm | diag_warning;
            `DIAG_WARN:       diag_event = diag_warning;
            default:          diag_event = diag_alarm;
        endcase
        case (src_sel)
            `SRC_BLOCK1: track_bit = discrete_function_block1;
            `SRC_BLOCK2: track_bit = discrete_function_block2;
            default:     track_bit = 1'b0;
        endcase
        case (func)
            `FUNC_OFF:     base_closed = 1'b0;
            `FUNC_ON:      base_closed = 1'b1;
            `FUNC_DIAG:    base_closed = ~diag_event;
            `FUNC_LIMIT:   base_closed = limit_state_r;
            `FUNC_DIGITAL: base_closed = track_bit;
            default:       base_closed = 1'b0;
        endcase
    end

    // Forced choices bypass the alarm override so simulation stays usable
    wire forced = (func == `FUNC_OFF) | (func == `FUNC_ON);
    reg  fail_closed;
    always @* begin
        fail_closed = base_closed;
        if (diag_alarm & ~forced) begin
            case (fail_sel)
                `FAIL_ACTUAL: fail_closed = base_closed;
                `FAIL_OPEN:   fail_closed = 1'b0;
                `FAIL_CLOSED: fail_closed = 1'b1;
                default:      fail_closed = 1'b0;
            endcase
        end
    end
    wire switch_nxt = fail_closed ^ invert;

    // Register next values; only full-word writes land
    reg  [31:0]      ctrl_nxt;
    reg  [VAL_W-1:0] on_val_nxt;
    reg  [VAL_W-1:0] off_val_nxt;
    reg  [9:0]       on_dly_nxt;
    reg  [9:0]       off_dly_nxt;
    always @* begin
        ctrl_nxt    = ctrl_r;
        on_val_nxt  = on_val_r;
        off_val_nxt = off_val_r;
        on_dly_nxt  = on_dly_r;
        off_dly_nxt = off_dly_r;
        if (wb_wr) begin
            case (wb_adr_i)
                `SW_CTRL_OFS: begin
                    // Bit 11 and the upper half read back as zero
                    ctrl_nxt = wb_dat_i & 32'h0000_F7FF;
                end
                `SW_ON_VAL_OFS: begin
                    on_val_nxt = wb_dat_i[VAL_W-1:0];
                end
                `SW_OFF_VAL_OFS: begin
                    off_val_nxt = wb_dat_i[VAL_W-1:0];
                end
                `SW_ON_DLY_OFS: begin
                    on_dly_nxt = dly_in;
                end
                `SW_OFF_DLY_OFS: begin
                    off_dly_nxt = dly_in;
                end
                default: begin
                    // Unmapped and status writes are acknowledged and dropped
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
    end

    // Status word: switch, limit state, delay pending
    wire [31:0] status_word = {29'h0000_0000, pending_r, limit_state_r, switch_closed};

    // Read data is captured with the request and holds until the next read
    reg  [31:0] rd_data_nxt;
    always @* begin
        rd_data_nxt = wb_dat_o;
        if (wb_req & ~wb_we_i) begin
            case (wb_adr_i)
                `SW_CTRL_OFS:    rd_data_nxt = ctrl_r;
                `SW_ON_VAL_OFS:  rd_data_nxt = on_val_r;
                `SW_OFF_VAL_OFS: rd_data_nxt = off_val_r;
                `SW_ON_DLY_OFS:  rd_data_nxt = {22'h000000, on_dly_r};
                `SW_OFF_DLY_OFS: rd_data_nxt = {22'h000000, off_dly_r};
                `SW_STATUS_OFS:  rd_data_nxt = status_word;
                default:         rd_data_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Registers and Wishbone answer
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r    <= `CTRL_RESET;
            on_val_r  <= {VAL_W{1'b0}};
            off_val_r <= {VAL_W{1'b0}};
            on_dly_r  <= 10'h000;
            off_dly_r <= 10'h000;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0000_0000;
        end else if (clk_en) begin
            // Ack is a one-cycle pulse; a strobe still held the cycle after the ack is taken again
            wb_ack_o  <= wb_req;
            wb_dat_o  <= rd_data_nxt;
            ctrl_r    <= ctrl_nxt;
            on_val_r  <= on_val_nxt;
            off_val_r <= off_val_nxt;
            on_dly_r  <= on_dly_nxt;
            off_dly_r <= off_dly_nxt;
        end
    end

    // Limit delay sequencer: one-hot, idle or counting toward a toggle
    localparam [1:0] LIM_IDLE = 2'b01;
    localparam [1:0] LIM_WAIT = 2'b10;
    reg  [1:0]  lim_st_r;
    reg  [1:0]  lim_st_nxt;
    reg         limit_state_nxt;
    reg  [31:0] tick_cnt_nxt;
    reg  [9:0]  dly_cnt_nxt;
    // Leaving limit mode or losing the condition drops any pending change
    wire        limit_go  = want_change & (func == `FUNC_LIMIT);
    wire [31:0] tick_step = tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    wire [9:0]  dly_step  = tick ? dly_cnt_r + 10'h001 : dly_cnt_r;

    always @* begin
        lim_st_nxt      = LIM_IDLE;
        limit_state_nxt = limit_state_r;
        tick_cnt_nxt    = 32'h0000_0000;
        dly_cnt_nxt     = 10'h000;
        case (lim_st_r)
            LIM_IDLE: begin
                if (limit_go) begin
                    if (dly_sel == 10'h000) begin
                        // Zero delay toggles at once, no pending cycle
                        limit_state_nxt = ~limit_state_r;
                    end else begin
                        lim_st_nxt   = LIM_WAIT;
                        tick_cnt_nxt = tick_step;
                        dly_cnt_nxt  = dly_step;
                    end
                end
            end
            LIM_WAIT: begin
                if (!limit_go) begin
                    // Cause cleared before the delay ran out
                    lim_st_nxt = LIM_IDLE;
                end else if (dly_cnt_r >= dly_sel) begin
                    limit_state_nxt = ~limit_state_r;
                end else begin
                    lim_st_nxt   = LIM_WAIT;
                    tick_cnt_nxt = tick_step;
                    dly_cnt_nxt  = dly_step;
                end
            end
            default: begin
                // Illegal codes fall back to idle
                lim_st_nxt = LIM_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            lim_st_r      <= LIM_IDLE;
            limit_state_r <= 1'b0;
            tick_cnt_r    <= 32'h0000_0000;
            dly_cnt_r     <= 10'h000;
            pending_r     <= 1'b0;
            switch_closed <= 1'b0;
        end else if (clk_en) begin
            lim_st_r      <= lim_st_nxt;
            limit_state_r <= limit_state_nxt;
            tick_cnt_r    <= tick_cnt_nxt;
            dly_cnt_r     <= dly_cnt_nxt;
            pending_r     <= (lim_st_nxt == LIM_WAIT);
            switch_closed <= switch_nxt;
        end
    end

endmodule
`default_nettype wire

/* File: verification/switch_load_model.sv */
// Load wired to the switch: current flows only while it conducts.
// Assumes switch_closed is the design's registered output.
`timescale 1ns/1ps
`default_nettype none
module switch_load_model (
    // Contact and sensed current
    input  wire logic switch_closed,
    output wire logic load_on
);
    assign load_on = switch_closed;
endmodule
`default_nettype wire

/* File: verification/switch_output_control_properties.sv */
// Port-level assertions for the switch output control block.
// Assumes full-word control writes; limit thresholds are not mirrored.
`timescale 1ns/1ps
`default_nettype none
`include "switch_output_defs.vh"
module switch_output_props (
    // Clock, reset and bus
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Events and switch
    input wire logic        diag_alarm,
    input wire logic        diag_warning,
    input wire logic        discrete_function_block1,
    input wire logic        discrete_function_block2,
    input wire logic        switch_closed
);
    logic [15:0] ctl_r;
    logic [15:0] ctl_q;
    wire  [2:0]  fn  = ctl_r[2:0];
    wire  [1:0]  cls = ctl_r[7:6];
    wire         ev  = cls == `DIAG_ALARM ? diag_alarm : cls == `DIAG_WARN ? diag_warning : diag_alarm | diag_warning;
    wire         trk = ctl_r[5:4] == `SRC_BLOCK1 ? discrete_function_block1 :
                       ctl_r[5:4] == `SRC_BLOCK2 && discrete_function_block2;
    wire         exp_c = ctl_r[10] ^ (fn == `FUNC_DIAG ? !ev : trk);
    // Settings steady and no write in flight, so latency cannot alias
    wire         quiet = ctl_q == ctl_r && !wb_ack_o;
    always_ff @(posedge ref_clk) begin
        ctl_q <= rst ? 16'h0100 : ctl_r;
        if (rst)
            ctl_r <= 16'h0100;
        else if (wb_ack_o && wb_we_i && wb_adr_i == `SW_CTRL_OFS && wb_sel_i == 4'hF)
            ctl_r <= wb_dat_i[15:0];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_OFF: assert property (quiet && fn == `FUNC_OFF |-> switch_closed == ctl_r[10])
        else $error("forced off wrong");
    AST_ON: assert property (quiet && fn == `FUNC_ON |-> switch_closed == !ctl_r[10])
        else $error("forced on wrong");
    AST_INV: assert property ($changed(ctl_r[10]) && ctl_q[2:0] == fn && fn < `FUNC_DIAG |-> switch_closed == (ctl_r[10] ^ fn[0]))
        else $error("inversion not applied");
    AST_DIAG: assert property (quiet && !diag_alarm && fn == `FUNC_DIAG |=> switch_closed == $past(exp_c))
        else $error("diagnostic state wrong");
    AST_TRACK: assert property (quiet && !diag_alarm && fn == `FUNC_DIGITAL |=> switch_closed == $past(exp_c))
        else $error("tracking state wrong");
    AST_FAIL: assert property (quiet && diag_alarm && fn >= `FUNC_DIAG && fn <= `FUNC_DIGITAL && ctl_r[9:8] != `FAIL_ACTUAL
        |=> switch_closed == (ctl_r[9] ^ ctl_r[10]))
        else $error("alarm override wrong");
    AST_HOLD: assert property (quiet && !diag_alarm && fn == `FUNC_LIMIT && ctl_r[15:12] == `VAR_NONE |=> $stable(switch_closed))
        else $error("limit without variable moved");
    AST_STATUS: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `SW_STATUS_OFS && $stable(switch_closed)
        |-> wb_dat_o[0] == switch_closed)
        else $error("status bit wrong");
    cover property (fn == `FUNC_DIAG && diag_warning);
    cover property (fn == `FUNC_LIMIT && $rose(switch_closed));
    cover property (wb_ack_o && wb_adr_i == `SW_STATUS_OFS);
endmodule
bind switch_output_control switch_output_props props_u (.ref_clk, .rst, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .diag_alarm, .diag_warning, .discrete_function_block1, .discrete_function_block2,
    .switch_closed);
`default_nettype wire

/* File: verification/switch_output_control_tb.sv */
// Bench for the switch output control block: bus tasks and mode sequences.
// Assumes a 50 MHz clock and the designer's register map.
`timescale 1ns/1ps
`default_nettype none
`include "switch_output_defs.vh"
module switch_output_control_tb;
    logic         ref_clk = 0, rst = 1, cyc = 0, we = 0, alm = 0, wrn = 0, b1 = 0, b2 = 0;
    logic         ack, sw, load_on, ev;
    logic [7:0]   adr = 0;
    logic [31:0]  dw = 0, dr, rd;
    logic [511:0] pv = 0;
    logic [9:0]   e = 10'h0C6;
    int           v[10] = '{0, 200, 75, 10, 75, 200, 10, 75, 200, 75};
    int           num_errors = 0, samples_checked = 0;
    always #10 ref_clk = ~ref_clk;
    switch_output_control #(.TENTH_TICKS(4)) dut_u (.ref_clk, .rst, .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .proc_vars(pv),
        .diag_alarm(alm), .diag_warning(wrn), .discrete_function_block1(b1), .discrete_function_block2(b2),
        .switch_closed(sw));
    switch_load_model load_u (.switch_closed(sw), .load_on(load_on));
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        cyc <= 1;
        we  <= w;
        adr <= a;
        dw  <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 0;
        rd = dr;
        if (n >= 20) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        bus(0, `SW_CTRL_OFS, 0);
        check(rd, `CTRL_RESET);
        bus(0, `SW_ON_DLY_OFS, 0);
        check(rd, `DLY_RESET);
        bus(0, 8'h40, 0);
        check(rd, 0);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            bus(1, `SW_CTRL_OFS, 32'h100 | i[0] << 10 | i[1]);
            repeat (3) @(posedge ref_clk);
            check({load_on, sw}, {2{i[0] ^ i[1]}});
        end
        for (int k = 0; k < 36; k++) begin
            bus(1, `SW_CTRL_OFS, `FUNC_DIAG | (k / 4 % 3) << 6 | k / 12 << 8);
            alm <= k[1];
            wrn <= k[0];
            repeat (3) @(posedge ref_clk);
            ev = k / 4 % 3 == 0 ? k[1] : k / 4 % 3 == 2 ? k[0] : k[1] | k[0];
            check(sw, k[1] && k >= 12 ? k >= 24 : !ev);
        end
        alm <= 0;
        wrn <= 0;
        for (int k = 0; k < 12; k++) begin
            bus(1, `SW_CTRL_OFS, `FUNC_DIGITAL | k / 4 << 4);
            b1 <= k[1];
            b2 <= k[0];
            repeat (3) @(posedge ref_clk);
            check(sw, k / 4 == 1 ? k[1] : k / 4 == 2 && k[0]);
        end
        $display("forced, diagnostic and tracking done");
        bus(1, `SW_ON_VAL_OFS, 100);
        bus(1, `SW_OFF_VAL_OFS, 50);
        bus(1, `SW_CTRL_OFS, 32'h1003);
        for (int i = 0; i < 10; i++) begin
            if (i == 5) begin
                // Off first, so no transient threshold pair closes the switch
                bus(1, `SW_OFF_VAL_OFS, 100);
                bus(1, `SW_ON_VAL_OFS, 50);
            end
            pv[32 +: 32] <= v[i];
            repeat (4) @(posedge ref_clk);
            check(sw, e[i]);
        end
        bus(1, `SW_ON_DLY_OFS, 2);
        bus(1, `SW_OFF_DLY_OFS, 2);
        pv[32 +: 32] <= 10;
        repeat (4) @(posedge ref_clk);
        check(sw, 0);
        repeat (10) @(posedge ref_clk);
        check(sw, 1);
        pv[32 +: 32] <= 200;
        repeat (3) @(posedge ref_clk);
        pv[32 +: 32] <= 75;
        repeat (12) @(posedge ref_clk);
        bus(0, `SW_STATUS_OFS, 0);
        check(rd[0], 1);
        bus(1, `SW_CTRL_OFS, `FUNC_LIMIT);
        pv[32 +: 32] <= 200;
        repeat (6) @(posedge ref_clk);
        check(sw, 1);
        $display("limit and delays done");
        report_and_stop();
    end
endmodule
`default_nettype wire
